// ### hdl/cpbsa_consts.svh
// constants for the coprocessor bus sizing acknowledge port
`ifndef CPBSA_CONSTS_SVH
`define CPBSA_CONSTS_SVH
// strap encodings: {width_n, addr_bit_zero}
`define CPBSA_STRAP_8_LO 2'b00
`define CPBSA_STRAP_8_HI 2'b01
`define CPBSA_STRAP_16 2'b10
`define CPBSA_STRAP_32 2'b11
// acknowledge pair encodings {upper_n, lower_n}
`define CPBSA_ACK_FULL 2'b00
`define CPBSA_ACK_UPPER 2'b01
`define CPBSA_ACK_LOWER 2'b10
`define CPBSA_ACK_WAIT 2'b11
// cycles of active negation after strobe rise
`define CPBSA_NEGATE_CYCLES 2'h1
// default wait states inserted before acknowledge
`define CPBSA_WAIT_CYCLES 4'h2
// host timeout in cycles while waiting for acknowledge
`define CPBSA_HOST_TIMEOUT 8'hff
`endif

// ### hdl/cpbsa_pkg.sv
// types for the coprocessor bus sizing acknowledge port
package cpbsa_pkg;
  // decoded port width
  typedef enum logic [1:0] {
    CPBSA_W8 = 2'b00,
    CPBSA_W16 = 2'b01,
    CPBSA_W32 = 2'b11
  } cpbsa_width_type;
  // device end sequence, gray along the usual path
  typedef enum logic [1:0] {
    CPBSA_D_IDLE = 2'b00,
    CPBSA_D_WAIT = 2'b01,
    CPBSA_D_ACK = 2'b11,
    CPBSA_D_NEG = 2'b10
  } cpbsa_dstate_type;
  // host end sequence, gray along the usual path
  typedef enum logic [1:0] {
    CPBSA_H_IDLE = 2'b00,
    CPBSA_H_STROBE = 2'b01,
    CPBSA_H_DONE = 2'b11,
    CPBSA_H_GAP = 2'b10
  } cpbsa_hstate_type;
endpackage : cpbsa_pkg

// ### hdl/cpbsa_bus_if.sv
// strobe bus between host processor and coprocessor port
`timescale 1ns/1ns
`default_nettype none
interface cpbsa_bus_if;
  logic addrStrobeN; // address strobe, active low
  logic dataStrobeN; // data strobe, active low
  logic chipSelectN; // chip select, active low
  logic readWrite; // high read, low write
  logic [4:0] addr; // register address, bit zero is addr_bit_zero
  logic [31:0] hostData; // host data drive
  logic hostDataOe; // host drives data
  logic [31:0] devData; // device data drive
  logic devDataOe; // device drives data
  logic [1:0] ackN; // device ack drive {upper, lower}
  logic [1:0] ackOe; // device ack enables
  // resolved data bus, last resort is all ones from the holding load
  wire [31:0] dataBus = devDataOe ? devData :
                        (hostDataOe ? hostData : 32'hffffffff);
  // ack lines held high by the external resistor when released
  wire ackUpperLaneN = ackOe[1] ? ackN[1] : 1'b1;
  wire ackLowerLaneN = ackOe[0] ? ackN[0] : 1'b1;
  modport device (
    input addrStrobeN, dataStrobeN, chipSelectN, readWrite, addr,
    input dataBus,
    output devData, devDataOe, ackN, ackOe
  );
  modport host (
    output addrStrobeN, dataStrobeN, chipSelectN, readWrite, addr,
    output hostData, hostDataOe,
    input dataBus, ackUpperLaneN, ackLowerLaneN
  );
endinterface : cpbsa_bus_if
`default_nettype wire

// ### hdl/cpbsa_device.sv
// device end: width strapping and dynamic size acknowledge
// ****************************************
// Overview of operation
// - 32-bit, address four high: both acks low
// - 32-bit, address four low: upper ack only
// - 16-bit: upper ack only, any address four
// - 8-bit: lower ack only, any address four
// - both acks high means wait, cycle open
// - width strap high, bit zero high: 32-bit
// - width strap high, bit zero low: 16-bit
// - width strap low: 8-bit, either bit zero level
// - 16-bit mode never asserts lower ack
// - 8-bit mode never asserts upper ack
// - 16-bit host uses upper ack only
// - 8-bit host uses lower ack only
// - peripheral host decodes select in data space; cpbsa_host asserts select on every request, with no address decode
// - acks active low, three-state; data three-state
// - after strobe rise drive high, then release
// - 32-bit address four low uses upper half
// ****************************************
`timescale 1ns/1ns
`default_nettype none
`include "cpbsa_consts.svh"
module cpbsa_device #(
  parameter logic [3:0] WAIT_CYCLES = `CPBSA_WAIT_CYCLES // ack delay
) (
  input wire logic ref_clk, // device clock, 25 MHz
  input wire logic sys_rst, // synchronous reset, active high
  cpbsa_bus_if.device bus, // strobe bus to the host
  input wire logic widthStrapN, // bus width strap, active low
  output logic [1:0] portWidth, // decoded width mode
  output logic [4:0] regAddr, // address of the access
  output logic regRead, // one-cycle read strobe
  output logic regWrite, // one-cycle write strobe
  output logic [31:0] regWdata, // write data, lane aligned
  input wire logic [31:0] regRdata // read data from the register file
);
  import cpbsa_pkg::*;

  // ****************************************
  // input synchronisers
  // ****************************************
  logic [4:0] asMeta_reg, asSync_reg; // strobes, select, rw, strap
  logic [4:0] addrMeta_reg, addrSync_reg; // address lines
  logic [31:0] dataMeta_reg, dataSync_reg; // data bus
  // two flops before any logic reads the pins
  always_ff @(posedge ref_clk) begin
    asMeta_reg <= {widthStrapN, bus.readWrite, bus.chipSelectN,
                   bus.dataStrobeN, bus.addrStrobeN};
    asSync_reg <= asMeta_reg;
    addrMeta_reg <= bus.addr;
    addrSync_reg <= addrMeta_reg;
    dataMeta_reg <= bus.dataBus;
    dataSync_reg <= dataMeta_reg;
  end
  wire asN = asSync_reg[0]; // synced address strobe
  wire dsN = asSync_reg[1]; // synced data strobe
  wire csN = asSync_reg[2]; // synced chip select
  wire rdWr = asSync_reg[3]; // synced direction
  wire strapN = asSync_reg[4]; // synced width strap

  // ****************************************
  // width decode
  // ****************************************
  // maps straps to a port width
  function automatic cpbsa_width_type widthOf(input logic [1:0] strap);
    case (strap)
      `CPBSA_STRAP_32: widthOf = CPBSA_W32;
      `CPBSA_STRAP_16: widthOf = CPBSA_W16;
      default: widthOf = CPBSA_W8;
    endcase
  endfunction : widthOf

  cpbsa_width_type width_reg; // static width mode
  logic strapDone_reg; // straps captured since reset
  // sampled once after reset release, then held
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      width_reg <= CPBSA_W8;
      strapDone_reg <= 1'b0;
    end else if (!strapDone_reg) begin
      width_reg <= widthOf({strapN, addrSync_reg[0]});
      strapDone_reg <= 1'b1;
    end
  end
  assign portWidth = width_reg;

  // ****************************************
  // acknowledge encoding
  // ****************************************
  wire a4 = addrSync_reg[4]; // address bit four
  wire [1:0] ackCode; // {upper_n, lower_n} for this access
  // 32-bit: full or upper half on address four
  // 16-bit never uses the lower ack
  // 8-bit never uses the upper ack
  assign ackCode = (width_reg == CPBSA_W32) ?
                   (a4 ? `CPBSA_ACK_FULL : `CPBSA_ACK_UPPER) :
                   ((width_reg == CPBSA_W16) ? `CPBSA_ACK_UPPER :
                    `CPBSA_ACK_LOWER);

  // ****************************************
  // cycle sequencer
  // ****************************************
  cpbsa_dstate_type state_reg, state_next; // sequencer state
  logic [3:0] waitCnt_reg, waitCnt_next; // wait-state counter
  logic [1:0] negCnt_reg, negCnt_next; // negation counter
  wire selected = !asN && !csN && strapDone_reg; // access begun
  wire strobeRose = asN || dsN; // either strobe released
  wire dataReady = rdWr || !dsN; // writes need data strobe
  wire ackGo = (waitCnt_reg == 4'h0) && dataReady; // time to answer
  // next-state decode
  always_comb begin
    state_next = state_reg;
    waitCnt_next = waitCnt_reg;
    negCnt_next = negCnt_reg;
    case (state_reg)
      // idle: wait for select under address strobe
      CPBSA_D_IDLE: begin
        waitCnt_next = WAIT_CYCLES;
        if (selected) begin
          state_next = CPBSA_D_WAIT;
        end
      end
      // both acks held high to insert waits
      CPBSA_D_WAIT: begin
        if (asN) begin
          state_next = CPBSA_D_IDLE; // host abandoned the cycle
        end else if (ackGo) begin
          state_next = CPBSA_D_ACK;
        end else if (waitCnt_reg != 4'h0) begin
          waitCnt_next = waitCnt_reg - 4'h1;
        end
      end
      // hold the answer until a strobe rises
      CPBSA_D_ACK: begin
        negCnt_next = `CPBSA_NEGATE_CYCLES;
        if (strobeRose) begin
          state_next = CPBSA_D_NEG;
        end
      end
      CPBSA_D_NEG: begin
        if (negCnt_reg != 2'h0) begin
          negCnt_next = negCnt_reg - 2'h1;
        end else if (asN && dsN) begin
          state_next = CPBSA_D_IDLE;
        end
      end
      default: state_next = CPBSA_D_IDLE;
    endcase
  end
  // state registers
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg <= CPBSA_D_IDLE;
      waitCnt_reg <= 4'h0;
      negCnt_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      waitCnt_reg <= waitCnt_next;
      negCnt_reg <= negCnt_next;
    end
  end

  // ****************************************
  // pin drivers
  // ****************************************
  wire enterAck = (state_reg == CPBSA_D_WAIT) && !asN && ackGo;
  logic [1:0] ackN_reg, ackOe_reg; // ack pin drive and enables
  logic [31:0] rdData_reg; // read data to the bus
  logic dataOe_reg; // data bus enable
  // acks driven while terminating and while negating, else released
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ackN_reg <= `CPBSA_ACK_WAIT;
      ackOe_reg <= 2'b00;
      rdData_reg <= 32'h00000000;
      dataOe_reg <= 1'b0;
    end else begin
      ackN_reg <= (state_next == CPBSA_D_ACK) ? ackCode : `CPBSA_ACK_WAIT;
      ackOe_reg <= (state_next == CPBSA_D_ACK ||
                    state_next == CPBSA_D_NEG) ? 2'b11 : 2'b00;
      if (enterAck && rdWr) begin
        rdData_reg <= regRdata;
      end
      dataOe_reg <= (state_next == CPBSA_D_ACK) && rdWr;
    end
  end
  assign bus.ackN = ackN_reg;
  assign bus.ackOe = ackOe_reg;
  assign bus.devData = rdData_reg;
  assign bus.devDataOe = dataOe_reg;

  // ****************************************
  // register side strobes
  // ****************************************
  logic [4:0] regAddr_reg; // captured address
  logic regRead_reg, regWrite_reg; // access pulses
  logic [31:0] regWdata_reg; // captured write data
  // one pulse per cycle, as the answer is committed
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      regAddr_reg <= 5'h00;
      regRead_reg <= 1'b0;
      regWrite_reg <= 1'b0;
      regWdata_reg <= 32'h00000000;
    end else begin
      regRead_reg <= enterAck && rdWr;
      regWrite_reg <= enterAck && !rdWr;
      if (selected && state_reg == CPBSA_D_IDLE) begin
        regAddr_reg <= addrSync_reg;
      end
      if (enterAck && !rdWr) begin
        regWdata_reg <= dataSync_reg;
      end
    end
  end
  assign regAddr = regAddr_reg;
  assign regRead = regRead_reg;
  assign regWrite = regWrite_reg;
  assign regWdata = regWdata_reg;
endmodule : cpbsa_device
`default_nettype wire

// ### hdl/cpbsa_host.sv
// host end: simple bus master that waits on the acknowledge lines
`timescale 1ns/1ns
`default_nettype none
`include "cpbsa_consts.svh"
module cpbsa_host #(
  parameter logic HOST_SIZING = 1'b1, // host decodes both acks
  parameter logic HOST_BYTE = 1'b0 // fixed-size host is byte wide
) (
  input wire logic ref_clk, // host clock, 25 MHz
  input wire logic sys_rst, // synchronous reset, active high
  cpbsa_bus_if.host bus, // strobe bus to the device
  input wire logic reqValid, // request valid
  output logic reqReady, // request taken
  input wire logic reqRead, // high read, low write
  input wire logic [4:0] reqAddr, // device register address
  input wire logic [31:0] reqWdata, // write data
  output logic rspValid, // one-cycle answer pulse
  output logic [31:0] rspRdata, // read data
  output logic [1:0] rspAck, // acks seen {upper_n, lower_n}
  output logic rspTimeout // cycle ended with no ack
);
  import cpbsa_pkg::*;

  // ****************************************
  // ack synchronisers
  // ****************************************
  logic [1:0] ackMeta_reg, ackSync_reg; // ack lines
  logic [31:0] datMeta_reg, datSync_reg; // data bus
  // two flops before any decision
  always_ff @(posedge ref_clk) begin
    ackMeta_reg <= {bus.ackUpperLaneN, bus.ackLowerLaneN};
    ackSync_reg <= ackMeta_reg;
    datMeta_reg <= bus.dataBus;
    datSync_reg <= datMeta_reg;
  end
  // fixed-size hosts use one ack as transfer ack
  wire hostTransferAckN = HOST_BYTE ? ackSync_reg[0] : ackSync_reg[1];
  // sizing host: any low ack ends the cycle; both high keeps it open
  wire acked = HOST_SIZING ? (ackSync_reg != `CPBSA_ACK_WAIT)
                           : !hostTransferAckN;

  // ****************************************
  // cycle sequencer
  // ****************************************
  cpbsa_hstate_type state_reg; // sequencer state
  logic [7:0] toCnt_reg; // timeout counter
  logic [4:0] addr_reg; // held address
  logic rd_reg; // held direction
  logic [31:0] wdata_reg; // held write data
  assign reqReady = (state_reg == CPBSA_H_IDLE);
  wire expired = (toCnt_reg == `CPBSA_HOST_TIMEOUT);
  // select is asserted with the strobes on every request, with no address decode
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg <= CPBSA_H_IDLE;
      toCnt_reg <= 8'h00;
      // bus idles on the requested address, so a strapped bit zero
      // level is already on the pins when the device reads its straps
      addr_reg <= reqAddr;
      rd_reg <= 1'b1;
      wdata_reg <= 32'h00000000;
      rspValid <= 1'b0;
      rspRdata <= 32'h00000000;
      rspAck <= `CPBSA_ACK_WAIT;
      rspTimeout <= 1'b0;
    end else begin
      rspValid <= 1'b0;
      case (state_reg)
        CPBSA_H_IDLE: begin
          toCnt_reg <= 8'h00;
          if (reqValid) begin
            addr_reg <= reqAddr;
            rd_reg <= reqRead;
            wdata_reg <= reqWdata;
            state_reg <= CPBSA_H_STROBE;
          end
        end
        // strobes stay low until an ack or timeout
        CPBSA_H_STROBE: begin
          toCnt_reg <= toCnt_reg + 8'h01;
          if (acked || expired) begin
            rspRdata <= datSync_reg;
            rspAck <= ackSync_reg;
            rspTimeout <= !acked;
            rspValid <= 1'b1;
            state_reg <= CPBSA_H_DONE;
          end
        end
        // strobes released; wait for device to let go
        CPBSA_H_DONE: begin
          if (ackSync_reg == `CPBSA_ACK_WAIT) begin
            state_reg <= CPBSA_H_GAP;
          end
        end
        CPBSA_H_GAP: state_reg <= CPBSA_H_IDLE;
        default: state_reg <= CPBSA_H_IDLE;
      endcase
    end
  end

  // ****************************************
  // pin drive
  // ****************************************
  wire active = (state_reg == CPBSA_H_STROBE); // strobes asserted
  assign bus.addrStrobeN = !active;
  assign bus.chipSelectN = !active;
  assign bus.dataStrobeN = !active;
  assign bus.readWrite = active ? rd_reg : 1'b1;
  assign bus.addr = addr_reg;
  assign bus.hostData = wdata_reg;
  assign bus.hostDataOe = active && !rd_reg;
endmodule : cpbsa_host
`default_nettype wire

// ### tb/cpbsa_monitor.sv
// concurrent checks on the strobe bus between host and device ends
`timescale 1ns/1ns
`default_nettype none
module cpbsa_monitor (
  input wire logic ref_clk, // bus clock
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic addrStrobeN, // address strobe, active low
  input wire logic readWrite, // high read
  input wire logic [4:0] addr, // register address
  input wire logic hostDataOe, // host drives data
  input wire logic devDataOe, // device drives data
  input wire logic [1:0] ackN, // device ack drive
  input wire logic [1:0] ackOe, // device ack enables
  input wire logic ackUpperLaneN, // resolved upper ack
  input wire logic ackLowerLaneN // resolved lower ack
);
  // ****************
  // helper logic
  // ****************
  wire [1:0] ackPair = {ackUpperLaneN, ackLowerLaneN}; // resolved pair
  wire ackSeen = (ackPair != 2'b11); // some lane acknowledging
  logic sawLow_reg; // lower-only answer since reset
  logic sawUp_reg; // upper answer since reset
  // lanes used so far; straps only change across a reset
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sawLow_reg <= 1'b0;
      sawUp_reg <= 1'b0;
    end else begin
      sawLow_reg <= sawLow_reg | (ackPair == 2'b10);
      sawUp_reg <= sawUp_reg | ~ackUpperLaneN;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // ****************
  // assertions
  // ****************
  // full width needs address four
  a_full_needs_a4: assert property (ackPair == 2'b00 |-> addr[4])
    else $error("full-width ack with address four low");
  a_lane_static: assert property (!(sawLow_reg && sawUp_reg))
    else $error("upper and lower-only acks seen in one configuration");
  a_ack_stable: assert property (ackSeen && $past(ackSeen) |->
    $stable(ackPair)) else $error("ack code changed while held");
  a_wait_first: assert property ($fell(addrStrobeN) |->
    !ackSeen[*3]) else $error("ack came before select was seen");
  a_ack_bounded: assert property ($fell(addrStrobeN) |->
    ##[1:12] ackSeen) else $error("no ack within twelve cycles");
  a_strobe_held: assert property ($rose(addrStrobeN) |->
    ($past(ackSeen) || $past(ackSeen, 2)))
    else $error("strobe released without an ack");
  a_negate_drive: assert property ($fell(ackSeen) |->
    ackOe == 2'b11 && ackN == 2'b11)
    else $error("acks not driven high after the cycle");
  a_release_soon: assert property ($fell(ackSeen) |->
    ##[1:4] ackOe == 2'b00) else $error("acks not released");
  a_write_no_drive: assert property (devDataOe && !addrStrobeN |->
    readWrite) else $error("device drives data in a write");
  a_no_bus_fight: assert property (!(devDataOe && hostDataOe))
    else $error("host and device both drive data");
  cover property (ackPair == 2'b00);
  cover property (ackPair == 2'b01);
  cover property (ackPair == 2'b10);
endmodule : cpbsa_monitor
`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench joining the host and device ends over the bus
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import cpbsa_pkg::*;
  logic ref_clk = 1'b0; // 25 MHz clock
  logic sys_rst = 1'b1; // synchronous reset
  logic widthStrapN = 1'b1; // width strap, active low
  logic reqValid = 1'b0; // request valid
  logic reqRead = 1'b0; // request direction
  logic [4:0] reqAddr = 5'h00; // request address
  logic [31:0] reqWdata = 32'h00000000; // request write data
  logic reqReady, rspValid, rspTimeout, regRead, regWrite;
  logic [31:0] rspRdata, regWdata, regRdata;
  logic [1:0] rspAck, portWidth;
  logic [4:0] regAddr, seenAddr;
  logic strapA0; // bit zero level at strap time
  int err_count, total_checks, rdPulses, wrPulses;
  // register file stand-in, data keyed by address
  assign regRdata = {27'h5a5a5a5, regAddr};
  always #20 ref_clk = ~ref_clk;
  cpbsa_bus_if cpbsa_bus_if_i ();
  cpbsa_device #(.WAIT_CYCLES(4'h2)) cpbsa_device_i (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .bus(cpbsa_bus_if_i.device),
    .widthStrapN(widthStrapN), .portWidth(portWidth), .regAddr(regAddr),
    .regRead(regRead), .regWrite(regWrite), .regWdata(regWdata),
    .regRdata(regRdata));
  cpbsa_host cpbsa_host_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .bus(cpbsa_bus_if_i.host), .reqValid(reqValid), .reqReady(reqReady),
    .reqRead(reqRead), .reqAddr(reqAddr), .reqWdata(reqWdata),
    .rspValid(rspValid), .rspRdata(rspRdata), .rspAck(rspAck),
    .rspTimeout(rspTimeout));
  cpbsa_monitor cpbsa_monitor_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .addrStrobeN(cpbsa_bus_if_i.addrStrobeN),
    .readWrite(cpbsa_bus_if_i.readWrite), .addr(cpbsa_bus_if_i.addr),
    .hostDataOe(cpbsa_bus_if_i.hostDataOe),
    .devDataOe(cpbsa_bus_if_i.devDataOe), .ackN(cpbsa_bus_if_i.ackN),
    .ackOe(cpbsa_bus_if_i.ackOe),
    .ackUpperLaneN(cpbsa_bus_if_i.ackUpperLaneN),
    .ackLowerLaneN(cpbsa_bus_if_i.ackLowerLaneN));
  // count register strobes and keep the address they carried
  always @(posedge ref_clk) begin
    if (regRead === 1'b1 || regWrite === 1'b1) begin
      seenAddr = regAddr;
    end
    rdPulses += (regRead === 1'b1);
    wrPulses += (regWrite === 1'b1);
  end
  // ending in one place keeps the verdict single
  task automatic stop_test;
    if (err_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test
  task automatic check2(input logic [1:0] got, input logic [1:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %b expected %b", $time, got, exp);
    end
  endtask : check2
  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check32
  // expected {upper_n, lower_n} for a strap pair and address four
  function automatic logic [1:0] exp_ack(input logic s, input logic a0,
      input logic a4);
    if (!s) return 2'b10;
    if (a0 && a4) return 2'b00;
    return 2'b01;
  endfunction : exp_ack
  // straps settle well before release, as the synchronisers need
  task automatic apply_reset(input logic strapN, input logic a0);
    @(posedge ref_clk);
    #1 sys_rst = 1'b1;
    widthStrapN = strapN;
    reqAddr = {4'h0, a0};
    repeat (6) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    strapA0 = a0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : apply_reset
  // one request through the host, bounded waits on both handshakes
  task automatic do_req(input logic rd, input logic [4:0] a,
      input logic [31:0] wd);
    int n;
    n = 0;
    reqValid = 1'b1;
    reqRead = rd;
    reqAddr = a;
    reqWdata = wd;
    while (reqReady !== 1'b1 && n < 400) begin
      @(posedge ref_clk);
      #1 n++;
    end
    @(posedge ref_clk);
    #1 reqValid = 1'b0;
    while (rspValid !== 1'b1 && n < 400) begin
      @(posedge ref_clk);
      #1 n++;
    end
    if (n >= 400) begin
      err_count++;
      $display("[ERR] %0t no answer from the bus", $time);
      stop_test();
    end
  endtask : do_req
  // reads at both address-four levels and a write in one configuration
  task automatic scen_mode(input logic s, input logic a0);
    logic [1:0] w;
    int r0;
    apply_reset(s, a0);
    w = !s ? 2'b00 : (strapA0 ? 2'b11 : 2'b01);
    check2(portWidth, w);
    r0 = rdPulses;
    do_req(1'b1, {4'h8, a0}, 32'h0);
    check2(rspAck, exp_ack(s, strapA0, 1'b1));
    check32({27'h0, seenAddr}, {27'h0, 4'h8, a0});
    check32(32'(rdPulses - r0), 32'h1);
    check2({1'b0, rspTimeout}, 2'b00);
    if (exp_ack(s, strapA0, 1'b1) == 2'b00) begin
      check32(rspRdata, {27'h5a5a5a5, 4'h8, a0});
    end
    do_req(1'b1, {4'h3, a0}, 32'h0);
    check2(rspAck, exp_ack(s, strapA0, 1'b0));
    r0 = wrPulses;
    do_req(1'b0, {4'h5, a0}, 32'hc3a5_1e0f);
    check2(rspAck, exp_ack(s, strapA0, 1'b0));
    check32(32'(wrPulses - r0), 32'h1);
    check32(regWdata, 32'hc3a5_1e0f);
    check32({27'h0, seenAddr}, {27'h0, 4'h5, a0});
  endtask : scen_mode
  // requests straight after each answer, no idle gap from the bench
  task automatic scen_back2back;
    int r0;
    r0 = rdPulses;
    do_req(1'b1, 5'h13, 32'h0);
    do_req(1'b1, 5'h02, 32'h0);
    check32(32'(rdPulses - r0), 32'h2);
    check32({27'h0, seenAddr}, 32'h2);
  endtask : scen_back2back
  initial begin
    err_count = 0;
    total_checks = 0;
    rdPulses = 0;
    wrPulses = 0;
    scen_mode(1'b1, 1'b1);
    scen_mode(1'b1, 1'b0);
    scen_back2back();
    scen_mode(1'b0, 1'b0);
    scen_mode(1'b0, 1'b1);
    scen_back2back();
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
